//--- interval_timer.sv
`timescale 1ns/1ns
`default_nettype none
module interval_timer #(
   parameter int ADDR_W = 8
) (
   // clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // axi4-lite write address
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   // axi4-lite write response
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // axi4-lite read address
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   // axi4-lite read data
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // power state
   input  wire logic              sleep_mode,
   // interrupt
   output logic                   irq
);
   if (ADDR_W < 8 || ADDR_W > 32) begin : g_chk
      $error("interval_timer: ADDR_W must lie in 8..32");
   end

   typedef struct packed {
      interval_timer_pkg::div_sel_t div_sel;
      logic              clk_sel;
      logic              run;
      logic              gate;
      logic [2:0]        presc;
      logic [15:0]       count;
      logic              flag;
      logic              ien;
      logic              pie;
      logic              global_irq_enable;
      logic              aw_hold;
      logic [ADDR_W-1:0] awaddr;
      logic              w_hold;
      logic [7:0]        wdata;
      logic              wlane;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              rvalid;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
   } tmr_st_t;

   tmr_st_t     st_ff;
   tmr_st_t     nxt_st;
   logic        sys_tick;
   logic        instr_tick;
   logic        src_tick;
   logic        active;
   logic        step;
   logic        rollover;
   logic        do_wr;
   logic        cnt_wr;
   logic [7:0]  ctrl_word;
   logic [7:0]  rd_byte;
   logic        rd_hit;

   // word-aligned offset match
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [7:0] off);
      hit = ({a[ADDR_W-1:2], 2'b00} == ADDR_W'(off));
   endfunction

   // ***************************************************
   // counter clock sources
   // ***************************************************
   rate_tick #(
      .CLK_MHZ  (interval_timer_pkg::AXI_CLK_MHZ),
      .RATE_MHZ (interval_timer_pkg::SYS_CLK_MHZ)
   ) u_sys_tick (
      .aclk    (aclk),
      .aresetn (aresetn),
      .tick    (sys_tick)
   );

   rate_tick #(
      .CLK_MHZ  (interval_timer_pkg::AXI_CLK_MHZ),
      .RATE_MHZ (interval_timer_pkg::INSTR_CLK_MHZ)
   ) u_instr_tick (
      .aclk    (aclk),
      .aresetn (aresetn),
      .tick    (instr_tick)
   );

   assign src_tick = st_ff.clk_sel ? sys_tick : instr_tick;
   assign active   = st_ff.run & st_ff.gate & ~sleep_mode;
   assign step     = active & src_tick &
      (st_ff.presc == interval_timer_pkg::div_mask(st_ff.div_sel));
   assign rollover = step & (st_ff.count == interval_timer_pkg::COUNT_MAX);

   // ***************************************************
   // register read view
   // ***************************************************
   always_comb begin
      ctrl_word = 8'h00;
      ctrl_word[interval_timer_pkg::DIV_MSB:interval_timer_pkg::DIV_LSB] =
         st_ff.div_sel;
      ctrl_word[interval_timer_pkg::CSEL_BIT] = st_ff.clk_sel;
      ctrl_word[interval_timer_pkg::RUN_BIT]  = st_ff.run;
   end

   // divider state is deliberately not mapped
   always_comb begin
      rd_byte = 8'h00;
      rd_hit  = 1'b1;
      if (hit(s_axi_araddr, interval_timer_pkg::CTRL_OFF)) begin
         rd_byte = ctrl_word;
      end else if (hit(s_axi_araddr, interval_timer_pkg::CNT_HI_OFF)) begin
         rd_byte = st_ff.count[15:8];
      end else if (hit(s_axi_araddr, interval_timer_pkg::CNT_LO_OFF)) begin
         rd_byte = st_ff.count[7:0];
      end else if (hit(s_axi_araddr, interval_timer_pkg::FLAG_OFF)) begin
         rd_byte[interval_timer_pkg::FLAG_BIT] = st_ff.flag;
      end else if (hit(s_axi_araddr, interval_timer_pkg::IEN_OFF)) begin
         rd_byte[interval_timer_pkg::IEN_BIT] = st_ff.ien;
      end else if (hit(s_axi_araddr, interval_timer_pkg::ICTL_OFF)) begin
         rd_byte[interval_timer_pkg::PIE_BIT] = st_ff.pie;
         rd_byte[interval_timer_pkg::GIE_BIT] = st_ff.global_irq_enable;
      end else begin
         rd_hit = 1'b0;
      end
   end

   // ***************************************************
   // bus handshakes
   // ***************************************************
   assign s_axi_awready = ~st_ff.aw_hold & ~st_ff.bvalid;
   assign s_axi_wready  = ~st_ff.w_hold & ~st_ff.bvalid;
   assign s_axi_arready = ~st_ff.rvalid;
   assign do_wr  = st_ff.aw_hold & st_ff.w_hold;
   assign cnt_wr = do_wr & st_ff.wlane &
      (hit(st_ff.awaddr, interval_timer_pkg::CNT_HI_OFF) |
       hit(st_ff.awaddr, interval_timer_pkg::CNT_LO_OFF));

   // ***************************************************
   // next state
   // ***************************************************
   always_comb begin
      nxt_st = st_ff;
      // write channel capture
      if (s_axi_awvalid && s_axi_awready) begin
         nxt_st.aw_hold = 1'b1;
         nxt_st.awaddr  = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         nxt_st.w_hold = 1'b1;
         nxt_st.wdata  = s_axi_wdata[7:0];
         nxt_st.wlane  = s_axi_wstrb[0];
      end
      if (st_ff.bvalid && s_axi_bready) begin
         nxt_st.bvalid = 1'b0;
      end
      // read channel
      if (st_ff.rvalid && s_axi_rready) begin
         nxt_st.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rdata  = {24'h000000, rd_byte};
         nxt_st.rresp  = rd_hit ? interval_timer_pkg::RESP_OKAY
                                : interval_timer_pkg::RESP_SLVERR;
      end
      // gate follows run one cycle late, drops the cycle after run is cleared
      nxt_st.gate = st_ff.run;
      // prescaler and count
      if (active && src_tick) begin
         if (step) begin
            nxt_st.presc = interval_timer_pkg::PRESC_RST;
            nxt_st.count = st_ff.count +
               interval_timer_pkg::COUNT_ONE;
         end else begin
            nxt_st.presc = st_ff.presc + interval_timer_pkg::PRESC_ONE;
         end
      end
      // register writes
      if (do_wr) begin
         nxt_st.aw_hold = 1'b0;
         nxt_st.w_hold  = 1'b0;
         nxt_st.bvalid  = 1'b1;
         nxt_st.bresp   = interval_timer_pkg::RESP_OKAY;
         if (hit(st_ff.awaddr, interval_timer_pkg::CTRL_OFF)) begin
            if (st_ff.wlane) begin
               nxt_st.div_sel = interval_timer_pkg::div_sel_t'(st_ff.wdata[
                  interval_timer_pkg::DIV_MSB:interval_timer_pkg::DIV_LSB]);
               nxt_st.clk_sel = st_ff.wdata[interval_timer_pkg::CSEL_BIT];
               nxt_st.run     = st_ff.wdata[interval_timer_pkg::RUN_BIT];
            end
         end else if (hit(st_ff.awaddr, interval_timer_pkg::CNT_HI_OFF)) begin
            if (st_ff.wlane) begin
               nxt_st.count[15:8] = st_ff.wdata;
               nxt_st.presc = interval_timer_pkg::PRESC_RST;
            end
         end else if (hit(st_ff.awaddr, interval_timer_pkg::CNT_LO_OFF)) begin
            if (st_ff.wlane) begin
               nxt_st.count[7:0] = st_ff.wdata;
               nxt_st.presc = interval_timer_pkg::PRESC_RST;
            end
         end else if (hit(st_ff.awaddr, interval_timer_pkg::FLAG_OFF)) begin
            if (st_ff.wlane && st_ff.wdata[interval_timer_pkg::FLAG_BIT]) begin
               nxt_st.flag = 1'b0;
            end
         end else if (hit(st_ff.awaddr, interval_timer_pkg::IEN_OFF)) begin
            if (st_ff.wlane) begin
               nxt_st.ien = st_ff.wdata[interval_timer_pkg::IEN_BIT];
            end
         end else if (hit(st_ff.awaddr, interval_timer_pkg::ICTL_OFF)) begin
            if (st_ff.wlane) begin
               nxt_st.pie = st_ff.wdata[interval_timer_pkg::PIE_BIT];
               nxt_st.global_irq_enable = st_ff.wdata[interval_timer_pkg::GIE_BIT];
            end
         end else begin
            nxt_st.bresp = interval_timer_pkg::RESP_SLVERR;
         end
      end
      // a wrap beats a clear in the same cycle
      if (rollover) begin
         nxt_st.flag = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff <= '{div_sel: interval_timer_pkg::DIV_1,
                    count:   interval_timer_pkg::COUNT_RST,
                    presc:   interval_timer_pkg::PRESC_RST,
                    bresp:   interval_timer_pkg::RESP_OKAY,
                    rresp:   interval_timer_pkg::RESP_OKAY,
                    default: '0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ***************************************************
   // outputs
   // ***************************************************
   assign s_axi_bvalid = st_ff.bvalid;
   assign s_axi_bresp  = st_ff.bresp;
   assign s_axi_rvalid = st_ff.rvalid;
   assign s_axi_rdata  = st_ff.rdata;
   assign s_axi_rresp  = st_ff.rresp;
   assign irq = st_ff.flag & st_ff.ien & st_ff.pie & st_ff.global_irq_enable &
                st_ff.run;

   // ***************************************************
   // checks
   // ***************************************************
   count_wrap_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (rollover && !cnt_wr) |=>
         (st_ff.count == interval_timer_pkg::COUNT_RST) && st_ff.flag)
      else $error("wrap did not reach zero with flag set");

   div_step_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (step && !cnt_wr) |=>
         st_ff.count == $past(st_ff.count) + interval_timer_pkg::COUNT_ONE)
      else $error("count did not step by one");

   presc_clear_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      cnt_wr |=> st_ff.presc == interval_timer_pkg::PRESC_RST)
      else $error("divider not cleared by count write");

   src_hold_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (!src_tick && !cnt_wr) |=>
         $stable(st_ff.count) && $stable(st_ff.presc))
      else $error("count moved without a source tick");

   irq_gate_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      irq |-> st_ff.flag && st_ff.ien && st_ff.pie && st_ff.global_irq_enable &&
              st_ff.run)
      else $error("interrupt raised without all enables");

   sleep_freeze_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (sleep_mode && !cnt_wr) |=> $stable(st_ff.count) && !$rose(st_ff.flag))
      else $error("timer moved during sleep");

   run_off_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (!st_ff.run && !do_wr) |=> !st_ff.gate && $stable(st_ff.count))
      else $error("stopped timer still gated or counting");

   ctrl_zero_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready &&
       hit(s_axi_araddr, interval_timer_pkg::CTRL_OFF)) |=>
         (s_axi_rdata[7:6] == 2'b00) && (s_axi_rdata[3:2] == 2'b00))
      else $error("unimplemented control bits not zero");

   hi_load_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (cnt_wr && hit(st_ff.awaddr, interval_timer_pkg::CNT_HI_OFF)) |=>
         st_ff.count[15:8] == $past(st_ff.wdata))
      else $error("high byte write not loaded");

   flag_stay_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (st_ff.flag && !(do_wr &&
         hit(st_ff.awaddr, interval_timer_pkg::FLAG_OFF))) |=> st_ff.flag)
      else $error("flag cleared without software");

   bresp_hold_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (s_axi_bvalid && !s_axi_bready) |=>
         s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before taken");
endmodule // interval_timer
`default_nettype wire

//--- interval_timer_pkg.sv
`default_nettype none
package interval_timer_pkg;
   // ***************************************************
   // clock rates
   // ***************************************************
   localparam int AXI_CLK_MHZ   = 20;
   localparam int SYS_CLK_MHZ   = 8;
   localparam int INSTR_DIV     = 4;
   localparam int INSTR_CLK_MHZ = SYS_CLK_MHZ / INSTR_DIV;
   // ***************************************************
   // register byte offsets
   // ***************************************************
   localparam logic [7:0] CTRL_OFF   = 8'h00;
   localparam logic [7:0] CNT_HI_OFF = 8'h04;
   localparam logic [7:0] CNT_LO_OFF = 8'h08;
   localparam logic [7:0] FLAG_OFF   = 8'h0c;
   localparam logic [7:0] IEN_OFF    = 8'h10;
   localparam logic [7:0] ICTL_OFF   = 8'h14;
   // ***************************************************
   // field positions
   // ***************************************************
   localparam int RUN_BIT  = 0;
   localparam int CSEL_BIT = 1;
   localparam int DIV_LSB  = 4;
   localparam int DIV_MSB  = 5;
   localparam int FLAG_BIT = 0;
   localparam int IEN_BIT  = 0;
   localparam int PIE_BIT  = 6;
   localparam int GIE_BIT  = 7;
   // ***************************************************
   // reset values and limits
   // ***************************************************
   localparam logic [15:0] COUNT_RST = 16'h0000;
   localparam logic [15:0] COUNT_MAX = 16'hffff;
   localparam logic [15:0] COUNT_ONE = 16'h0001;
   localparam logic [2:0]  PRESC_RST = 3'h0;
   localparam logic [2:0]  PRESC_ONE = 3'h1;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   // ***************************************************
   // divider select
   // ***************************************************
   typedef enum logic [1:0] {
      DIV_1 = 2'b00,
      DIV_2 = 2'b01,
      DIV_4 = 2'b10,
      DIV_8 = 2'b11
   } div_sel_t;
   // last prescale count before a counter step
   function automatic logic [2:0] div_mask(input div_sel_t sel);
      case (sel)
         DIV_1:   div_mask = 3'h0;
         DIV_2:   div_mask = 3'h1;
         DIV_4:   div_mask = 3'h3;
         DIV_8:   div_mask = 3'h7;
         default: div_mask = 3'h0;
      endcase
   endfunction
endpackage
`default_nettype wire

//--- rate_tick.sv
`timescale 1ns/1ns
`default_nettype none
module rate_tick #(
   parameter int CLK_MHZ  = 20,
   parameter int RATE_MHZ = 8
) (
   // clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // one-cycle pulse at the rate
   output logic      tick
);
   localparam int ACC_W = $clog2(CLK_MHZ + RATE_MHZ + 1);
   localparam logic [ACC_W-1:0] CLK_V  = ACC_W'(CLK_MHZ);
   localparam logic [ACC_W-1:0] RATE_V = ACC_W'(RATE_MHZ);
   localparam logic [ACC_W-1:0] ACC_0  = '0;

   if (RATE_MHZ < 1 || RATE_MHZ > CLK_MHZ) begin : g_chk
      $error("rate_tick: rate must lie in 1..CLK_MHZ");
   end

   typedef struct packed {
      logic [ACC_W-1:0] acc;
      logic             tick;
   } tick_st_t;

   tick_st_t st_ff;
   tick_st_t nxt_st;
   logic [ACC_W-1:0] sum;

   // ***************************************************
   // fractional accumulator
   // ***************************************************
   always_comb begin
      nxt_st = st_ff;
      sum = st_ff.acc + RATE_V;
      if (sum >= CLK_V) begin
         nxt_st.acc  = sum - CLK_V;
         nxt_st.tick = 1'b1;
      end else begin
         nxt_st.acc  = sum;
         nxt_st.tick = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff <= '{acc: ACC_0, tick: 1'b0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign tick = st_ff.tick;
endmodule // rate_tick
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
   // ***************************************************
   // signals
   // ***************************************************
   logic        aclk;
   logic        aresetn;
   logic [7:0]  s_axi_awaddr;
   logic        s_axi_awvalid;
   logic        s_axi_awready;
   logic [31:0] s_axi_wdata;
   logic        s_axi_wvalid;
   logic        s_axi_wready;
   logic [1:0]  s_axi_bresp;
   logic        s_axi_bvalid;
   logic        s_axi_bready;
   logic [7:0]  s_axi_araddr;
   logic        s_axi_arvalid;
   logic        s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0]  s_axi_rresp;
   logic        s_axi_rvalid;
   logic        sleep_mode;
   logic        irq;
   int          failures;
   int          n_tests;

   always #25 aclk = ~aclk;

   interval_timer u_interval_timer (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(4'h1), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(1'b1), .sleep_mode(sleep_mode), .irq(irq));

   // ***************************************************
   // compare and bus tasks
   // ***************************************************
   task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task automatic check_range(input logic [7:0] got, input int lo,
                              input int hi);
      n_tests++;
      if ((^got === 1'bx) || (got < lo) || (got > hi)) begin
         failures++;
         $display("unexpected at %0t: %h not in %0d..%0d", $time, got, lo, hi);
      end
   endtask

   task automatic axi_write(input logic [7:0] addr, input logic [7:0] data,
                            output logic [1:0] resp);
      logic aw_p;
      logic w_p;
      logic ta;
      logic tw;
      logic done;
      logic seen;
      aw_p = 1'b1;
      w_p = 1'b1;
      done = 1'b0;
      s_axi_awaddr  <= addr;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= {24'h000000, data};
      s_axi_wvalid  <= 1'b1;
      while (aw_p || w_p) begin
         @(negedge aclk);
         ta = aw_p && (s_axi_awready === 1'b1);
         tw = w_p && (s_axi_wready === 1'b1);
         @(posedge aclk);
         if (ta) begin
            aw_p = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (tw) begin
            w_p = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (!done) begin
         @(negedge aclk);
         done = s_axi_bready && (s_axi_bvalid === 1'b1);
         seen = (s_axi_bvalid === 1'b1);
         resp = s_axi_bresp;
         @(posedge aclk);
         s_axi_bready <= seen && !done;
      end
   endtask

   task automatic axi_read(input logic [7:0] addr, output logic [7:0] data,
                           output logic [1:0] resp);
      logic done;
      done = 1'b0;
      s_axi_araddr  <= addr;
      s_axi_arvalid <= 1'b1;
      while (!done) begin
         @(negedge aclk);
         done = (s_axi_arready === 1'b1);
         @(posedge aclk);
      end
      s_axi_arvalid <= 1'b0;
      done = 1'b0;
      while (!done) begin
         @(negedge aclk);
         done = (s_axi_rvalid === 1'b1);
         data = s_axi_rdata[7:0];
         resp = s_axi_rresp;
         @(posedge aclk);
      end
   endtask

   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      logic [1:0] r;
      axi_write(addr, data, r);
   endtask

   task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
      logic [7:0] d;
      logic [1:0] r;
      axi_read(addr, d, r);
      check_val(d, exp);
   endtask

   task automatic irq_chk(input logic exp);
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      check_val({7'h00, irq}, {7'h00, exp});
      @(posedge aclk);
   endtask

   // ***************************************************
   // scenarios
   // ***************************************************
   task automatic t_regs;
      logic [7:0] d;
      logic [1:0] r;
      rd_chk(interval_timer_pkg::CTRL_OFF, 8'h00);
      rd_chk(interval_timer_pkg::CNT_HI_OFF, 8'h00);
      rd_chk(interval_timer_pkg::FLAG_OFF, 8'h00);
      wr(interval_timer_pkg::CTRL_OFF, 8'hfe);
      rd_chk(interval_timer_pkg::CTRL_OFF, 8'h32);
      wr(interval_timer_pkg::CTRL_OFF, 8'h00);
      axi_write(8'h20, 8'hff, r);
      check_val({6'h00, r}, {6'h00, interval_timer_pkg::RESP_SLVERR});
      axi_read(8'h18, d, r);
      check_val({6'h00, r}, {6'h00, interval_timer_pkg::RESP_SLVERR});
   endtask

   task automatic t_run_fast(input logic [7:0] hi, input logic [7:0] lo);
      logic [7:0] d;
      logic [1:0] r;
      wr(interval_timer_pkg::CNT_HI_OFF, hi);
      wr(interval_timer_pkg::CNT_LO_OFF, lo);
      rd_chk(interval_timer_pkg::CNT_LO_OFF, lo);
      wr(interval_timer_pkg::CTRL_OFF, 8'h03);
      repeat (100) @(posedge aclk);
      wr(interval_timer_pkg::CTRL_OFF, 8'h00);
      axi_read(interval_timer_pkg::CNT_LO_OFF, d, r);
      check_range(d, 18, 34);
   endtask

   task automatic t_carry_wrap;
      t_run_fast(8'h00, 8'hf0);
      rd_chk(interval_timer_pkg::CNT_HI_OFF, 8'h01);
      rd_chk(interval_timer_pkg::FLAG_OFF, 8'h00);
      t_run_fast(8'hff, 8'hf0);
      rd_chk(interval_timer_pkg::CNT_HI_OFF, 8'h00);
      rd_chk(interval_timer_pkg::FLAG_OFF, 8'h01);
      repeat (50) @(posedge aclk);
      rd_chk(interval_timer_pkg::FLAG_OFF, 8'h01);
   endtask

   task automatic t_irq;
      logic [7:0] tbl [4][3];
      tbl = '{'{8'h00, 8'hc0, 8'h00}, '{8'h01, 8'h80, 8'h00},
              '{8'h01, 8'h40, 8'h00}, '{8'h01, 8'hc0, 8'h01}};
      wr(interval_timer_pkg::CNT_HI_OFF, 8'h00);
      wr(interval_timer_pkg::CNT_LO_OFF, 8'h00);
      wr(interval_timer_pkg::FLAG_OFF, 8'h01);
      wr(interval_timer_pkg::IEN_OFF, 8'h01);
      wr(interval_timer_pkg::ICTL_OFF, 8'hc0);
      irq_chk(1'b0);
      wr(interval_timer_pkg::CNT_HI_OFF, 8'hff);
      wr(interval_timer_pkg::CNT_LO_OFF, 8'hfe);
      wr(interval_timer_pkg::CTRL_OFF, 8'h03);
      repeat (10) @(posedge aclk);
      irq_chk(1'b1);
      for (int i = 0; i < 4; i++) begin
         wr(interval_timer_pkg::IEN_OFF, tbl[i][0]);
         wr(interval_timer_pkg::ICTL_OFF, tbl[i][1]);
         irq_chk(tbl[i][2][0]);
      end
      wr(interval_timer_pkg::CTRL_OFF, 8'h00);
      irq_chk(1'b0);
      wr(interval_timer_pkg::FLAG_OFF, 8'h01);
      irq_chk(1'b0);
      rd_chk(interval_timer_pkg::FLAG_OFF, 8'h00);
   endtask

   task automatic t_rates;
      logic [7:0] first;
      logic [7:0] second;
      logic [1:0] r;
      int         rate;
      int         div;
      for (int cs = 0; cs < 2; cs++) begin
         for (int d = 0; d < 4; d++) begin
            rate = (cs == 1) ? 8 : 2;
            div = 1 << d;
            wr(interval_timer_pkg::CNT_LO_OFF, 8'h00);
            wr(interval_timer_pkg::CNT_HI_OFF, 8'h00);
            wr(interval_timer_pkg::CTRL_OFF, {2'b00, d[1:0], 2'b00, cs[0], 1'b1});
            repeat (200) @(posedge aclk);
            wr(interval_timer_pkg::CTRL_OFF, 8'h00);
            axi_read(interval_timer_pkg::CNT_LO_OFF, first, r);
            check_range(first, (rate*10-2)/div-1, rate*11/div+1);
            repeat (40) @(posedge aclk);
            axi_read(interval_timer_pkg::CNT_LO_OFF, second, r);
            check_val(second, first);
         end
      end
   endtask

   task automatic t_prescale;
      wr(interval_timer_pkg::CNT_LO_OFF, 8'h00);
      wr(interval_timer_pkg::CNT_HI_OFF, 8'h00);
      wr(interval_timer_pkg::CTRL_OFF, 8'h31);
      repeat (55) @(posedge aclk);
      wr(interval_timer_pkg::CNT_LO_OFF, 8'h55);
      repeat (55) @(posedge aclk);
      wr(interval_timer_pkg::CTRL_OFF, 8'h00);
      rd_chk(interval_timer_pkg::CNT_LO_OFF, 8'h55);
   endtask

   task automatic t_sleep;
      sleep_mode <= 1'b1;
      wr(interval_timer_pkg::CNT_LO_OFF, 8'h00);
      wr(interval_timer_pkg::CTRL_OFF, 8'h03);
      repeat (100) @(posedge aclk);
      wr(interval_timer_pkg::CTRL_OFF, 8'h00);
      sleep_mode <= 1'b0;
      rd_chk(interval_timer_pkg::CNT_LO_OFF, 8'h00);
      irq_chk(1'b0);
   endtask

   // ***************************************************
   // run control
   // ***************************************************
   task automatic complete_run;
      $display("failures %0d n_tests %0d", failures, n_tests);
      if (failures == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      s_axi_awaddr = 8'h00;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h00000000;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = 8'h00;
      s_axi_arvalid = 1'b0;
      sleep_mode = 1'b0;
      failures = 0;
      n_tests = 0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs;
      t_carry_wrap;
      t_irq;
      t_rates;
      t_prescale;
      t_sleep;
      complete_run;
   end

   initial begin
      repeat (20000) @(posedge aclk);
      failures++;
      $display("unexpected at %0t: watchdog expired", $time);
      complete_run;
   end
endmodule // testbench
`default_nettype wire
